// *** fbm_fabric_master_port.sv ***
// Fabric end of one master port: accepts master transfers, runs them
// on the decoded slave port, returns read data and stalls the master.
// Assumes master and slaves are synchronous logic on mclk.
//
// Notes on behaviour
// - Setup cycles apply equally to reads and writes of a slave.
// - Slave stall mode with setup or hold is rejected and flagged.
// - Fabric accepts master transfer, then runs and ends the slave one.
// - All bus signals sampled and changed on the single system clock.
// - Stall request always present, high while transfer cannot complete.
// - Flag slave interrupt with 6-bit code, smaller code wins.
// - Packet end flag tells master the slave reached end of packet.
// - Latent valid high for one cycle, the first in which read word holds returned data.
// - Master flush discards every outstanding latent read.
// - Both sides agree polarity; strobes and lane selects active low.
// - Read starts at an edge with address and read request valid.
// - Stall raised before next edge, held until slave data ready on fundamental reads.
`timescale 1ns/1ps
module fbm_fabric_master_port (
  input wire logic mclk,
  input wire logic nrst,
  input fbm_pkg::fbm_mreq_t mreq,
  input wire logic flush,
  output logic stall_request,
  output logic [fbm_pkg::DW-1:0] read_word,
  output logic latent_data_valid,
  output logic packet_end_flag,
  output logic interrupt_request,
  output logic [fbm_pkg::PRIW-1:0] interrupt_priority_code,
  output logic config_error,
  output fbm_pkg::fbm_sreq_t sreq,
  input wire logic [fbm_pkg::NSLV-1:0][fbm_pkg::DW-1:0] slave_read_word,
  input wire logic [fbm_pkg::NSLV-1:0] slave_stall,
  input wire logic [fbm_pkg::NSLV-1:0] slave_irq,
  input wire logic [fbm_pkg::NSLV-1:0] slave_end_of_packet
);

  fbm_pkg::fbm_state_t state_r;
  fbm_pkg::fbm_state_t state_nxt;
  fbm_pkg::fbm_sreq_t sreq_r;
  logic [fbm_pkg::NSLV-1:0] sel_r;
  logic rd_r;
  logic wr_r;
  logic [fbm_pkg::DW-1:0] read_word_r;
  logic latent_valid_r;
  logic eop_r;
  logic irq_r;
  logic [fbm_pkg::PRIW-1:0] pri_r;
  logic cfg_err_r;
  logic [fbm_pkg::LAT_CYC-1:0] pend_r;

  logic req;
  logic req_rd;
  logic [fbm_pkg::NSLV-1:0] dec_sel;
  fbm_pkg::fbm_scfg_t cfg_dec;
  fbm_pkg::fbm_scfg_t cfg_cur;
  logic [fbm_pkg::CNTW-1:0] setup_dec;
  logic [fbm_pkg::CNTW-1:0] hold_cur;
  logic [fbm_pkg::NSLV-1:0] bad_vec;
  logic accept;
  logic access_end;
  logic latent_push;
  logic cur_stall;
  logic [fbm_pkg::DW-1:0] cur_rdata;
  logic cur_eop;
  logic tmr_load;
  logic [fbm_pkg::CNTW-1:0] tmr_val;
  logic tmr_expired;
  logic latent_ret;
  logic [fbm_pkg::PRIW-1:0] pri_nxt;
  logic irq_nxt;

  fbm_phase_timer u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_expired)
  );

  // Master request decode, strobes active low
  assign req_rd = !mreq.read_n;
  assign req = req_rd || !mreq.write_n;
  assign dec_sel = fbm_pkg::decode(mreq.addr);

  // Per-slave configuration check
  always_comb begin
    for (int i = 0; i < fbm_pkg::NSLV; i++) begin
      bad_vec[i] = fbm_pkg::cfg_bad(fbm_pkg::SLV_CFG[i]);
    end
  end

  // Configuration of the slave being decoded and of the current slave
  always_comb begin
    cfg_dec = '0;
    cfg_cur = '0;
    cur_stall = 1'h0;
    cur_rdata = fbm_pkg::READ_WORD_RST;
    cur_eop = 1'h0;
    for (int i = 0; i < fbm_pkg::NSLV; i++) begin
      if (dec_sel[i]) begin
        cfg_dec = fbm_pkg::SLV_CFG[i];
      end
      if (sel_r[i]) begin
        cfg_cur = fbm_pkg::SLV_CFG[i];
        cur_stall = slave_stall[i];
        cur_rdata = slave_read_word[i];
        cur_eop = slave_end_of_packet[i];
      end
    end
  end

  // Rejected slaves run without setup or hold
  always_comb begin
    setup_dec = fbm_pkg::cfg_bad(cfg_dec) ? fbm_pkg::CNT_ZERO : cfg_dec.setup;
    hold_cur = fbm_pkg::cfg_bad(cfg_cur) ? fbm_pkg::CNT_ZERO : cfg_cur.hold;
  end

  // Fundamental reads wait while latent data is still due
  assign accept = (state_r == fbm_pkg::ST_IDLE) && req &&
    !(req_rd && !cfg_dec.latent && (pend_r != '0));

  // Slave access ends on its own stall or after its wait states
  always_comb begin
    if (cfg_cur.periph_ctl && !fbm_pkg::cfg_bad(cfg_cur)) begin
      access_end = !cur_stall;
    end else begin
      access_end = tmr_expired;
    end
  end

  assign latent_push = (state_r == fbm_pkg::ST_ACCESS) && access_end &&
    rd_r && cfg_cur.latent && !flush;

  // Next state of the transfer sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      fbm_pkg::ST_IDLE: begin
        if (accept) begin
          if (dec_sel == '0) begin
            state_nxt = fbm_pkg::ST_DONE;
          end else if (setup_dec != fbm_pkg::CNT_ZERO) begin
            state_nxt = fbm_pkg::ST_SETUP;
          end else begin
            state_nxt = fbm_pkg::ST_ACCESS;
          end
        end
      end
      fbm_pkg::ST_SETUP: begin
        if (tmr_expired) begin
          state_nxt = fbm_pkg::ST_ACCESS;
        end
      end
      fbm_pkg::ST_ACCESS: begin
        if (access_end) begin
          if (hold_cur != fbm_pkg::CNT_ZERO) begin
            state_nxt = fbm_pkg::ST_HOLD;
          end else begin
            state_nxt = fbm_pkg::ST_DONE;
          end
        end
      end
      fbm_pkg::ST_HOLD: begin
        if (tmr_expired) begin
          state_nxt = fbm_pkg::ST_DONE;
        end
      end
      fbm_pkg::ST_DONE: begin
        state_nxt = fbm_pkg::ST_IDLE;
      end
    endcase
  end

  // Timer loads for setup, wait and hold phases
  always_comb begin
    tmr_load = 1'h0;
    tmr_val = fbm_pkg::CNT_ZERO;
    if (accept && (dec_sel != '0)) begin
      tmr_load = 1'h1;
      if (setup_dec != fbm_pkg::CNT_ZERO) begin
        tmr_val = setup_dec - fbm_pkg::CNT_ONE;
      end else begin
        tmr_val = cfg_dec.wait_states;
      end
    end else if ((state_r == fbm_pkg::ST_SETUP) && tmr_expired) begin
      tmr_load = 1'h1;
      tmr_val = cfg_cur.wait_states;
    end else if ((state_r == fbm_pkg::ST_ACCESS) && access_end &&
        (hold_cur != fbm_pkg::CNT_ZERO)) begin
      tmr_load = 1'h1;
      tmr_val = hold_cur - fbm_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= fbm_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Captured transfer kind and slave select
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sel_r <= '0;
      rd_r <= 1'h0;
      wr_r <= 1'h0;
    end else if (accept) begin
      sel_r <= dec_sel;
      rd_r <= req_rd;
      wr_r <= !mreq.write_n;
    end
  end

  // Slave-side request bus, chip select spans setup and hold
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sreq_r <= fbm_pkg::SREQ_RST;
    end else if (accept && (dec_sel != '0)) begin
      sreq_r.chip_select <= dec_sel;
      sreq_r.addr <= mreq.addr;
      sreq_r.lane_select_low <= mreq.lane_select_low;
      sreq_r.write_word <= mreq.write_word;
      if (setup_dec == fbm_pkg::CNT_ZERO) begin
        sreq_r.read_n <= mreq.read_n;
        sreq_r.write_n <= mreq.write_n;
      end
    end else if ((state_r == fbm_pkg::ST_SETUP) && tmr_expired) begin
      sreq_r.read_n <= !rd_r;
      sreq_r.write_n <= !wr_r;
    end else if ((state_r == fbm_pkg::ST_ACCESS) && access_end) begin
      sreq_r.read_n <= 1'h1;
      sreq_r.write_n <= 1'h1;
      if (hold_cur == fbm_pkg::CNT_ZERO) begin
        sreq_r.chip_select <= '0;
      end
    end else if ((state_r == fbm_pkg::ST_HOLD) && tmr_expired) begin
      sreq_r.chip_select <= '0;
    end
  end

  // Outstanding latent reads, cleared by flush
  assign latent_ret = pend_r[fbm_pkg::LAT_CYC-1] && !flush;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pend_r <= '0;
    end else if (flush) begin
      pend_r <= '0;
    end else begin
      pend_r <= {pend_r[fbm_pkg::LAT_CYC-2:0], latent_push};
    end
  end

  // Read word capture for fundamental and latent reads
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      read_word_r <= fbm_pkg::READ_WORD_RST;
      latent_valid_r <= 1'h0;
    end else begin
      latent_valid_r <= latent_ret;
      if (latent_ret) begin
        read_word_r <= cur_rdata;
      end else if (accept && req_rd && (dec_sel == '0)) begin
        read_word_r <= fbm_pkg::READ_WORD_RST;
      end else if ((state_r == fbm_pkg::ST_ACCESS) && access_end && rd_r &&
          !cfg_cur.latent) begin
        read_word_r <= cur_rdata;
      end
    end
  end

  // End of packet from the slave that ended the last access
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      eop_r <= 1'h0;
    end else if (accept) begin
      eop_r <= 1'h0;
    end else if ((state_r == fbm_pkg::ST_ACCESS) && access_end) begin
      eop_r <= cur_eop;
    end
  end

  // Pending interrupt with the smallest code among requesting slaves
  always_comb begin
    irq_nxt = 1'h0;
    pri_nxt = fbm_pkg::PRI_CODE_RST;
    for (int i = 0; i < fbm_pkg::NSLV; i++) begin
      if (slave_irq[i] && (!irq_nxt ||
          (fbm_pkg::SLV_CFG[i].irq_code < pri_nxt))) begin
        irq_nxt = 1'h1;
        pri_nxt = fbm_pkg::SLV_CFG[i].irq_code;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'h0;
      pri_r <= fbm_pkg::PRI_CODE_RST;
    end else begin
      irq_r <= irq_nxt;
      pri_r <= pri_nxt;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_err_r <= 1'h0;
    end else begin
      cfg_err_r <= |bad_vec;
    end
  end

  // Stall high from the first request cycle until the done cycle
  always_comb begin
    unique case (state_r)
      fbm_pkg::ST_IDLE: stall_request = req;
      fbm_pkg::ST_DONE: stall_request = 1'h0;
      default: stall_request = 1'h1;
    endcase
  end

  assign read_word = read_word_r;
  assign latent_data_valid = latent_valid_r;
  assign packet_end_flag = eop_r;
  assign interrupt_request = irq_r;
  assign interrupt_priority_code = pri_r;
  assign config_error = cfg_err_r;
  assign sreq = sreq_r;

endmodule : fbm_fabric_master_port

// *** fbm_pkg.sv ***
// Shared types and constants for the fabric master-port read block.
// Assumes one clock, all master and slave ports in the same domain.
package fbm_pkg;

  localparam int AW = 32;
  localparam int DW = 32;
  localparam int LW = 4;
  localparam int NSLV = 3;
  localparam int PRIW = 6;
  localparam int CNTW = 4;

  // Latent slave returns data this many cycles after its strobe cycle
  localparam int LAT_CYC = 2;

  // Values after reset and counter constants
  localparam logic [DW-1:0] READ_WORD_RST = 32'h0000_0000;
  localparam logic [PRIW-1:0] PRI_CODE_RST = 6'h3F;
  localparam logic [CNTW-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNTW-1:0] CNT_ONE = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACCESS,
    ST_HOLD,
    ST_DONE
  } fbm_state_t;

  // Master port request group, strobes and lane selects active low
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [LW-1:0] lane_select_low;
    logic [DW-1:0] write_word;
    logic read_n;
    logic write_n;
  } fbm_mreq_t;

  // Shared slave-side request bus with one chip select per slave
  typedef struct packed {
    logic [NSLV-1:0] chip_select;
    logic [AW-1:0] addr;
    logic [LW-1:0] lane_select_low;
    logic [DW-1:0] write_word;
    logic read_n;
    logic write_n;
  } fbm_sreq_t;

  localparam fbm_sreq_t SREQ_RST = '{
    chip_select: 3'h0,
    addr: 32'h0000_0000,
    lane_select_low: 4'hF,
    write_word: 32'h0000_0000,
    read_n: 1'h1,
    write_n: 1'h1
  };

  // Per-slave configuration
  typedef struct packed {
    logic [AW-1:0] base;
    logic [AW-1:0] mask;
    logic [CNTW-1:0] setup;
    logic [CNTW-1:0] wait_states;
    logic [CNTW-1:0] hold;
    logic periph_ctl;
    logic latent;
    logic [PRIW-1:0] irq_code;
  } fbm_scfg_t;

  localparam fbm_scfg_t SLV_CFG [NSLV] = '{
    '{base: 32'h0000_0000, mask: 32'hFFFF_0000, setup: 4'h1,
      wait_states: 4'h2, hold: 4'h1, periph_ctl: 1'h0, latent: 1'h0,
      irq_code: 6'h05},
    '{base: 32'h0001_0000, mask: 32'hFFFF_F000, setup: 4'h0,
      wait_states: 4'h0, hold: 4'h0, periph_ctl: 1'h1, latent: 1'h0,
      irq_code: 6'h02},
    '{base: 32'h0002_0000, mask: 32'hFFFF_F000, setup: 4'h0,
      wait_states: 4'h0, hold: 4'h0, periph_ctl: 1'h0, latent: 1'h1,
      irq_code: 6'h09}
  };

  // Slave stall mode combined with setup or hold is not allowed
  function automatic logic cfg_bad(input fbm_scfg_t c);
    cfg_bad = c.periph_ctl && ((c.setup != CNT_ZERO) || (c.hold != CNT_ZERO));
  endfunction : cfg_bad

  // Address decode to a one-hot slave select
  function automatic logic [NSLV-1:0] decode(input logic [AW-1:0] a);
    logic [NSLV-1:0] s;
    s = '0;
    for (int i = 0; i < NSLV; i++) begin
      s[i] = ((a & SLV_CFG[i].mask) == SLV_CFG[i].base);
    end
    decode = s;
  endfunction : decode

endpackage : fbm_pkg

// *** fbm_phase_timer.sv ***
// Down counter that times setup, wait and hold phases of a slave access.
// Assumes load is a one-cycle pulse from the fabric sequencer.
`timescale 1ns/1ps
module fbm_phase_timer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [fbm_pkg::CNTW-1:0] load_val,
  output logic expired
);

  logic [fbm_pkg::CNTW-1:0] count_r;

  // Counts down to zero and rests there
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_r <= fbm_pkg::CNT_ZERO;
    end else if (load) begin
      count_r <= load_val;
    end else if (count_r != fbm_pkg::CNT_ZERO) begin
      count_r <= count_r - fbm_pkg::CNT_ONE;
    end
  end

  assign expired = (count_r == fbm_pkg::CNT_ZERO);

endmodule : fbm_phase_timer

// *** fbm_checker.sv ***
// Assertions on the fabric master port, bound to its ports.
// Assumes the slave map of the package and a single mclk domain.
`timescale 1ns/1ps
module fbm_checker (
  input wire logic mclk,
  input wire logic nrst,
  input fbm_pkg::fbm_mreq_t mreq,
  input wire logic flush,
  input wire logic stall_request,
  input wire logic [fbm_pkg::DW-1:0] read_word,
  input wire logic latent_data_valid,
  input wire logic interrupt_request,
  input wire logic [fbm_pkg::PRIW-1:0] interrupt_priority_code,
  input wire logic config_error,
  input fbm_pkg::fbm_sreq_t sreq,
  input wire logic [fbm_pkg::NSLV-1:0][fbm_pkg::DW-1:0] slave_read_word,
  input wire logic [fbm_pkg::NSLV-1:0] slave_stall,
  input wire logic [fbm_pkg::NSLV-1:0] slave_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_cfg;
    $past(nrst) |-> !config_error;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config error raised");
  property p_rd_stall;
    $fell(mreq.read_n) |-> stall_request;
  endproperty
  a_rd_stall: assert property (p_rd_stall)
    else $error("no stall in first read cycle");
  property p_setup;
    $rose(sreq.chip_select[0]) && !mreq.read_n |-> sreq.read_n
      ##1 !sreq.read_n [*3] ##1 (sreq.read_n && sreq.chip_select[0])
      ##1 (!sreq.chip_select[0] && !stall_request);
  endproperty
  a_setup: assert property (p_setup)
    else $error("slave0 read phases wrong");
  property p_nosetup;
    $rose(sreq.chip_select[1]) |-> !sreq.read_n && stall_request;
  endproperty
  a_nosetup: assert property (p_nosetup)
    else $error("slave1 strobe late");
  property p_hold;
    sreq.chip_select[1] && slave_stall[1]
      |=> sreq.chip_select[1] && stall_request;
  endproperty
  a_hold: assert property (p_hold)
    else $error("slave stall not honoured");
  property p_addr;
    (|sreq.chip_select) |-> sreq.addr == mreq.addr
      && sreq.lane_select_low == mreq.lane_select_low;
  endproperty
  a_addr: assert property (p_addr)
    else $error("slave address differs");
  property p_irq;
    slave_irq[1] |=> interrupt_request && interrupt_priority_code == 6'h02;
  endproperty
  a_irq: assert property (p_irq)
    else $error("priority code wrong");
  property p_noirq;
    slave_irq == 3'h0 |=> !interrupt_request
      && interrupt_priority_code == 6'h3F;
  endproperty
  a_noirq: assert property (p_noirq)
    else $error("idle interrupt wrong");
  property p_lat_data;
    latent_data_valid |-> read_word == $past(slave_read_word[2]);
  endproperty
  a_lat_data: assert property (p_lat_data)
    else $error("latent data wrong");
  property p_lat_time;
    $rose(sreq.chip_select[2]) && !sreq.read_n && !flush ##1 !flush
      ##1 !flush |=> latent_data_valid ##1 !latent_data_valid;
  endproperty
  a_lat_time: assert property (p_lat_time)
    else $error("latent valid timing wrong");
  property p_flush;
    $rose(sreq.chip_select[2]) && flush |-> ##3 !latent_data_valid;
  endproperty
  a_flush: assert property (p_flush)
    else $error("flushed read returned");

  c_setup: cover property ($rose(sreq.chip_select[0]));
  c_stall: cover property (sreq.chip_select[1] && slave_stall[1]);
  c_lat: cover property (latent_data_valid);
  c_irq: cover property (interrupt_request);
endmodule : fbm_checker

bind fbm_fabric_master_port fbm_checker chk_u (
  .mclk(mclk), .nrst(nrst), .mreq(mreq), .flush(flush),
  .stall_request(stall_request), .read_word(read_word),
  .latent_data_valid(latent_data_valid),
  .interrupt_request(interrupt_request),
  .interrupt_priority_code(interrupt_priority_code),
  .config_error(config_error), .sreq(sreq),
  .slave_read_word(slave_read_word), .slave_stall(slave_stall),
  .slave_irq(slave_irq)
);

// *** fbm_master_model.sv ***
// Master peripheral model issuing fundamental reads on request.
// Assumes the fabric port on the same mclk.
`timescale 1ns/1ps
module fbm_master_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic go,
  input wire logic [fbm_pkg::AW-1:0] go_addr,
  input wire logic stall_request,
  input wire logic [fbm_pkg::DW-1:0] read_word,
  output fbm_pkg::fbm_mreq_t mreq,
  output logic done,
  output logic [fbm_pkg::DW-1:0] rdata
);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mreq.addr <= 32'h0;
      mreq.lane_select_low <= 4'h0;
      mreq.write_word <= 32'h0;
      mreq.read_n <= 1'h1;
      mreq.write_n <= 1'h1;
      done <= 1'h0;
      rdata <= 32'h0;
    end else begin
      done <= 1'h0;
      // Outputs held while stalled, no time-out
      if (!mreq.read_n && !stall_request) begin
        rdata <= read_word;
        done <= 1'h1;
        if (go) begin
          mreq.addr <= go_addr;
        end else begin
          mreq.read_n <= 1'h1;
          mreq.addr <= ~mreq.addr;
        end
      end else if (mreq.read_n && go) begin
        mreq.addr <= go_addr;
        mreq.read_n <= 1'h0;
      end
    end
  end
endmodule : fbm_master_model

// *** fbm_fabric_master_port_tb.sv ***
// Testbench for the fabric master port with a master model.
// Assumes the slave map and latency of the package.
`timescale 1ns/1ps
module fbm_fabric_master_port_tb;
  localparam logic [31:0] W0 = 32'hA5A5_0000;
  localparam logic [31:0] W1 = 32'h5A5A_1111;
  localparam logic [31:0] W2 = 32'hC3C3_2222;
  logic mclk, nrst, go, flush, done, stall_request, latent_data_valid;
  logic packet_end_flag, interrupt_request, config_error, seen;
  logic [fbm_pkg::AW-1:0] go_addr;
  logic [fbm_pkg::DW-1:0] read_word, rdata;
  logic [fbm_pkg::PRIW-1:0] irq_code;
  logic [2:0] slave_stall, slave_irq, slave_eop;
  fbm_pkg::fbm_mreq_t mreq;
  fbm_pkg::fbm_sreq_t sreq;
  int fails, samples_checked;
  int cyc = 0;

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  fbm_fabric_master_port dut_u (
    .mclk(mclk), .nrst(nrst), .mreq(mreq), .flush(flush),
    .stall_request(stall_request), .read_word(read_word),
    .latent_data_valid(latent_data_valid),
    .packet_end_flag(packet_end_flag),
    .interrupt_request(interrupt_request),
    .interrupt_priority_code(irq_code), .config_error(config_error),
    .sreq(sreq), .slave_read_word({W2, W1, W0}),
    .slave_stall(slave_stall), .slave_irq(slave_irq),
    .slave_end_of_packet(slave_eop)
  );

  fbm_master_model mst_u (
    .mclk(mclk), .nrst(nrst), .go(go), .go_addr(go_addr),
    .stall_request(stall_request), .read_word(read_word),
    .mreq(mreq), .done(done), .rdata(rdata)
  );

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick

  task automatic wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    chk({31'h0, done}, 32'h1);
  endtask : wait_done

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    go = 1'b1;
    go_addr = a;
    tick(1);
    go = 1'b0;
    wait_done();
    chk(rdata, e);
  endtask : rd

  task automatic t_stall;
    slave_stall = 3'h2;
    go = 1'b1;
    go_addr = 32'h0001_0004;
    tick(1);
    go = 1'b0;
    tick(4);
    chk({31'h0, done}, 32'h0);
    chk({31'h0, stall_request}, 32'h1);
    slave_stall = 3'h0;
    wait_done();
    chk(rdata, W1);
    $display("test stall done");
  endtask : t_stall

  task automatic t_b2b;
    go = 1'b1;
    go_addr = 32'h0001_0008;
    tick(1);
    go_addr = 32'h0000_0020;
    wait_done();
    chk(rdata, W1);
    go = 1'b0;
    tick(1);
    wait_done();
    chk(rdata, W0);
    $display("test back to back done");
  endtask : t_b2b

  task automatic t_latent(input logic fl);
    int n;
    seen = 1'b0;
    go = 1'b1;
    go_addr = 32'h0002_0000;
    tick(1);
    go = 1'b0;
    flush = fl;
    for (n = 0; n < 8; n++) begin
      if (n == 4) flush = 1'b0;
      if (latent_data_valid === 1'b1 && seen === 1'b0) begin
        seen = 1'b1;
        chk(read_word, W2);
      end
      tick(1);
    end
    chk({31'h0, seen}, {31'h0, ~fl});
    $display("test latent done");
  endtask : t_latent

  task automatic t_irq;
    logic [2:0] v [4] = '{3'h5, 3'h7, 3'h4, 3'h0};
    logic [5:0] c [4] = '{6'h05, 6'h02, 6'h09, 6'h3F};
    for (int i = 0; i < 4; i++) begin
      slave_irq = v[i];
      tick(2);
      chk({26'h0, irq_code}, {26'h0, c[i]});
      chk({31'h0, interrupt_request}, {31'h0, |v[i]});
    end
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_eop;
    slave_eop = 3'h2;
    rd(32'h0001_0000, W1);
    tick(1);
    chk({31'h0, packet_end_flag}, 32'h1);
    slave_eop = 3'h0;
    $display("test end of packet done");
  endtask : t_eop

  initial begin
    nrst = 1'b0;
    go = 1'b0;
    go_addr = 32'h0;
    flush = 1'b0;
    slave_stall = 3'h0;
    slave_irq = 3'h0;
    slave_eop = 3'h0;
    repeat (8) @(posedge mclk);
    #2;
    nrst = 1'b1;
    tick(2);
    chk({31'h0, config_error}, 32'h0);
    rd(32'h0000_0010, W0);
    $display("test setup done");
    rd(32'h0005_0000, 32'h0);
    $display("test unmapped done");
    t_stall();
    t_b2b();
    t_latent(1'b0);
    t_latent(1'b1);
    t_irq();
    t_eop();
    print_verdict();
  end
endmodule : fbm_fabric_master_port_tb
